// ==== design/wei_pkg.sv ====
package wei_pkg;
  localparam logic [7:0] WEI_PWR_CTRL_OFS = 8'h84;
  localparam logic [7:0] WEI_HARDWARE_CONFIG_REG_OFS = 8'h74;
  localparam int WEI_MODE_LSB = 12;
  localparam int WEI_LINK_EN_BIT = 9;
  localparam int WEI_ENERGY_EN_BIT = 8;
  localparam int WEI_DRIVE_BIT = 6;
  localparam int WEI_CAUSE_LSB = 4;
  localparam int WEI_PULSE_BIT = 3;
  localparam int WEI_POL_BIT = 2;
  localparam int WEI_PIN_EN_BIT = 1;
  localparam int WEI_READY_BIT = 0;
  localparam logic [1:0] WEI_CAUSE_NONE = 2'h0;
  localparam logic [1:0] WEI_CAUSE_ENERGY = 2'h1;
  localparam logic [1:0] WEI_CAUSE_FRAME = 2'h2;
  localparam logic [1:0] WEI_CAUSE_MULTI = 2'h3;
  localparam logic [1:0] WEI_FULL_POWER_STATE = 2'h0;
  localparam logic [1:0] WEI_FRAME_WAKE_STATE = 2'h1;
  localparam logic [1:0] WEI_ENERGY_WAKE_STATE = 2'h2;
  localparam logic [1:0] WEI_STATE_RSVD = 2'h3;
  localparam int WEI_PULSE_MS = 50;
  localparam int WEI_CLK_KHZ = 250000;
  localparam int WEI_PULSE_CYCLES = WEI_PULSE_MS * WEI_CLK_KHZ;
  localparam int WEI_POLL_GAP_CYCLES = 16;
  typedef enum logic [1:0] {
    WEI_H_IDLE = 2'b00,
    WEI_H_READ = 2'b01
  } wei_host_st_t;
endpackage

// ==== design/wei_bus_if.sv ====
`timescale 1ns/1ps
interface wei_bus_if;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;
  logic pme_out;
  logic pme_oe;
  logic pme_wire;

  // Board pull-up keeps the wired-or line high when nobody drives it
  assign pme_wire = pme_oe ? pme_out : 1'b1;

  modport dev (
    input addr, wr, rd, wdata,
    output rdata, rvalid, pme_out, pme_oe
  );
  modport host (
    output addr, wr, rd, wdata,
    input rdata, rvalid, pme_wire
  );
endinterface

// ==== design/wei_device.sv ====
`timescale 1ns/1ps
module wei_device
  import wei_pkg::*;
#(
  parameter int PULSE_CYCLES = WEI_PULSE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  wei_bus_if.dev bus,
  input wire logic link_wake_event_i,
  input wire logic energy_event_i,
  input wire logic link_src_pending_i,
  input wire logic energy_src_pending_i,
  input wire logic stable_i,
  output logic power_event_interrupt_o,
  output logic [1:0] power_state_select_o
);

  typedef struct packed {
    logic [2:0] stab_sync;
    logic stab;
    logic [1:0] power_state_select;
    logic link_wake_enable;
    logic energy_wake_enable;
    logic wake_pin_drive_type;
    logic [1:0] wake_cause;
    logic wake_pulse_select;
    logic wake_pin_polarity;
    logic wake_pin_enable;
    logic ready;
    logic [31:0] pulse_cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic pme_out;
    logic pme_oe;
  } wei_dev_state_t;

  wei_dev_state_t cur;
  wei_dev_state_t next_cur;

  function automatic logic [31:0] wei_pack(input wei_dev_state_t s);
    logic [31:0] v;
    v = 32'h0;
    v[WEI_MODE_LSB +: 2] = s.power_state_select;
    v[WEI_LINK_EN_BIT] = s.link_wake_enable;
    v[WEI_ENERGY_EN_BIT] = s.energy_wake_enable;
    v[WEI_DRIVE_BIT] = s.wake_pin_drive_type;
    v[WEI_CAUSE_LSB +: 2] = s.wake_cause;
    v[WEI_PULSE_BIT] = s.wake_pulse_select;
    v[WEI_POL_BIT] = s.wake_pin_polarity;
    v[WEI_PIN_EN_BIT] = s.wake_pin_enable;
    v[WEI_READY_BIT] = s.ready;
    return v;
  endfunction

  // Full power is the only state in which cause clears are taken
  function automatic logic wei_is_full(input logic [1:0] mode);
    return mode == WEI_FULL_POWER_STATE;
  endfunction

  // Map the sources that fired this cycle onto the cause code
  function automatic logic [1:0] wei_cause_code(input logic link,
      input logic energy);
    logic [1:0] c;
    case ({link, energy})
      2'b01: c = WEI_CAUSE_ENERGY;
      2'b10: c = WEI_CAUSE_FRAME;
      2'b11: c = WEI_CAUSE_MULTI;
      default: c = WEI_CAUSE_NONE;
    endcase
    return c;
  endfunction

  // Open drain only pulls low, so polarity means nothing there
  function automatic logic [1:0] wei_pin_drive(input logic active,
      input logic pol, input logic push_pull);
    logic [1:0] d;
    if (push_pull) begin
      d = {pol ? active : !active, 1'b1};
    end else begin
      d = {1'b0, active};
    end
    return d;
  endfunction

  // Decode of this cycle's bus request and wake events
  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic full_power;
  logic clr_ok;
  logic link_hit;
  logic energy_hit;
  logic any_hit;
  logic [1:0] set_bits;
  logic [1:0] clr_bits;
  logic [1:0] new_mode;
  logic src_live;
  logic pin_active;
  logic [1:0] pin_drive;

  always_comb begin
    next_cur = cur;
    // Only the power control offset is decoded; others read back zero
    sel = bus.addr == WEI_PWR_CTRL_OFS;
    wr_hit = bus.wr && sel;
    rd_hit = bus.rd && sel;
    full_power = wei_is_full(cur.power_state_select);
    new_mode = bus.wdata[WEI_MODE_LSB +: 2];
    link_hit = link_wake_event_i && cur.link_wake_enable;
    energy_hit = energy_event_i && cur.energy_wake_enable;
    any_hit = link_hit || energy_hit;
    set_bits = wei_cause_code(link_hit, energy_hit);
    // Clears are refused until the device is ready in full power
    clr_ok = wr_hit && cur.ready && full_power;
    clr_bits = 2'h0;
    // A source still pending keeps its cause bit from clearing
    if (clr_ok) begin
      clr_bits = bus.wdata[WEI_CAUSE_LSB +: 2] &
        ~{link_src_pending_i, energy_src_pending_i};
    end
    // Set wins over clear in the same cycle
    next_cur.wake_cause = (cur.wake_cause & ~clr_bits) | set_bits;

    // Stable is asynchronous to us: three flops, two must agree
    next_cur.stab_sync = {cur.stab_sync[1:0], stable_i};
    if (cur.stab_sync[1] == cur.stab_sync[2]) begin
      next_cur.stab = cur.stab_sync[2];
    end

    if (wr_hit) begin
      next_cur.link_wake_enable = bus.wdata[WEI_LINK_EN_BIT];
      next_cur.energy_wake_enable = bus.wdata[WEI_ENERGY_EN_BIT];
      next_cur.wake_pin_drive_type = bus.wdata[WEI_DRIVE_BIT];
      next_cur.wake_pulse_select = bus.wdata[WEI_PULSE_BIT];
      next_cur.wake_pin_polarity = bus.wdata[WEI_POL_BIT];
      next_cur.wake_pin_enable = bus.wdata[WEI_PIN_EN_BIT];
      // Reserved code is refused and the state left as it was
      if (new_mode != WEI_STATE_RSVD) begin
        next_cur.power_state_select = new_mode;
      end
    end
    // A wake event returns the device to full power by itself
    if (any_hit && !full_power) begin
      next_cur.power_state_select = WEI_FULL_POWER_STATE;
    end
    // Ready follows the state one edge later, so a sleep write drops it
    next_cur.ready = cur.stab && full_power;

    // Every enabled wake event restarts the pulse, so back-to-back events stretch it
    if (any_hit) begin
      next_cur.pulse_cnt = 32'(PULSE_CYCLES);
    end else if (cur.pulse_cnt != 32'h0) begin
      next_cur.pulse_cnt = cur.pulse_cnt - 32'h1;
    end

    // Power control stays readable in every state
    next_cur.rvalid = bus.rd;
    next_cur.rdata = 32'h0;
    if (rd_hit) begin
      next_cur.rdata = wei_pack(cur);
    end

    src_live = |(cur.wake_cause &
      {cur.link_wake_enable, cur.energy_wake_enable});
    pin_active = cur.wake_pin_enable && src_live &&
      (cur.wake_pulse_select ? cur.pulse_cnt != 32'h0 : 1'b1);
    pin_drive = wei_pin_drive(pin_active, cur.wake_pin_polarity,
      cur.wake_pin_drive_type);
    next_cur.pme_out = pin_drive[1];
    next_cur.pme_oe = pin_drive[0];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.rdata = cur.rdata;
  assign bus.rvalid = cur.rvalid;
  assign bus.pme_out = cur.pme_out;
  assign bus.pme_oe = cur.pme_oe;
  assign power_event_interrupt_o = |cur.wake_cause;
  assign power_state_select_o = cur.power_state_select;

endmodule

// ==== design/wei_host.sv ====
`timescale 1ns/1ps
module wei_host
  import wei_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  wei_bus_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [31:0] rsp_data_o,
  output logic ready_seen_o,
  output logic pme_level_o
);

  typedef struct packed {
    wei_host_st_t st;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
    logic poll;
    logic ready_seen;
    logic [7:0] poll_cnt;
    logic rsp_valid;
    logic rsp_err;
    logic [31:0] rsp_data;
    logic [2:0] pin_sync;
    logic pme_lvl;
  } wei_host_state_t;

  wei_host_state_t cur;
  wei_host_state_t next_cur;
  logic allowed;
  logic is_pwr;

  always_comb begin
    next_cur = cur;
    next_cur.wr = 1'b0;
    next_cur.rd = 1'b0;
    next_cur.rsp_valid = 1'b0;
    next_cur.rsp_err = 1'b0;
    next_cur.pin_sync = {cur.pin_sync[1:0], bus.pme_wire};
    if (cur.pin_sync[1] == cur.pin_sync[2]) begin
      next_cur.pme_lvl = cur.pin_sync[2];
    end
    is_pwr = cmd_addr_i == WEI_PWR_CTRL_OFS;
    // Before ready only power control, and reads of config, may go out
    allowed = cur.ready_seen || is_pwr ||
      (!cmd_write_i && cmd_addr_i == WEI_HARDWARE_CONFIG_REG_OFS);
    if (cur.poll_cnt != 8'h0) begin
      next_cur.poll_cnt = cur.poll_cnt - 8'h1;
    end
    case (cur.st)
      WEI_H_IDLE: begin
        if (cmd_valid_i) begin
          if (!allowed) begin
            next_cur.rsp_valid = 1'b1;
            next_cur.rsp_err = 1'b1;
          end else begin
            next_cur.addr = cmd_addr_i;
            next_cur.wdata = cmd_wdata_i;
            next_cur.poll = 1'b0;
            if (cmd_write_i) begin
              next_cur.wr = 1'b1;
              next_cur.rsp_valid = 1'b1;
              // Leaving full power drops readiness until re-polled
              if (is_pwr && cmd_wdata_i[WEI_MODE_LSB +: 2] !=
                  WEI_FULL_POWER_STATE) begin
                next_cur.ready_seen = 1'b0;
              end
            end else begin
              next_cur.rd = 1'b1;
              next_cur.st = WEI_H_READ;
            end
          end
        end else if (!cur.ready_seen && cur.poll_cnt == 8'h0) begin
          next_cur.addr = WEI_PWR_CTRL_OFS;
          next_cur.rd = 1'b1;
          next_cur.poll = 1'b1;
          next_cur.st = WEI_H_READ;
        end
      end
      WEI_H_READ: begin
        if (bus.rvalid) begin
          next_cur.st = WEI_H_IDLE;
          if (cur.addr == WEI_PWR_CTRL_OFS) begin
            next_cur.ready_seen = bus.rdata[WEI_READY_BIT];
          end
          if (cur.poll) begin
            next_cur.poll_cnt = 8'(WEI_POLL_GAP_CYCLES);
          end else begin
            next_cur.rsp_valid = 1'b1;
            next_cur.rsp_data = bus.rdata;
          end
        end
      end
      default: begin
        next_cur.st = WEI_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.addr = cur.addr;
  assign bus.wr = cur.wr;
  assign bus.rd = cur.rd;
  assign bus.wdata = cur.wdata;
  assign cmd_ready_o = cur.st == WEI_H_IDLE;
  assign rsp_valid_o = cur.rsp_valid;
  assign rsp_err_o = cur.rsp_err;
  assign rsp_data_o = cur.rsp_data;
  assign ready_seen_o = cur.ready_seen;
  assign pme_level_o = cur.pme_lvl;

endmodule

// ==== tb/wei_props.sv ====
`timescale 1ns/1ps
module wei_props #(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic pme_out,
  input wire logic pme_oe
);
  typedef struct packed {
    logic [3:0] cfg;
    logic [3:0] cfg_d;
  } wei_chk_t;
  wei_chk_t st;
  wei_chk_t next_st;
  logic drv, pls, pol, pen, calm, act;
  always_comb begin
    next_st = st;
    next_st.cfg_d = st.cfg;
    if (wr && addr == 8'h84) begin
      next_st.cfg = {wdata[6], wdata[3:1]};
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign {drv, pls, pol, pen} = st.cfg;
  // Pin regs lag the fields, so the pin is judged only once settled
  assign calm = st.cfg == st.cfg_d;
  assign act = pme_oe && (drv ? pme_out == pol : 1'b1);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rise;
    $rose(act) && calm && pls;
  endsequence
  sequence s_pulse;
    act [*8] ##[1:PULSE_CYCLES] !act;
  endsequence
  property p_rd_ans;
    rd && addr == 8'h84 |=> rvalid;
  endproperty
  property p_no_ans;
    !rd |=> !rvalid;
  endproperty
  property p_state;
    rvalid |-> rdata[13:12] != 2'h3;
  endproperty
  property p_od;
    calm && !drv |-> !pme_out;
  endproperty
  property p_pp;
    calm && drv |-> pme_oe;
  endproperty
  property p_pol;
    calm && drv && !pen |-> pme_out == !pol;
  endproperty
  property p_pin_off;
    calm && !drv && !pen |-> !pme_oe;
  endproperty
  property p_pulse;
    s_rise |-> s_pulse;
  endproperty
  property p_hold;
    calm && !pls && pen && act && !wr && !$past(wr) |=> act;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_no_ans: assert property (p_no_ans)
    else $error("stray answer");
  a_state: assert property (p_state)
    else $error("reserved state shown");
  a_od: assert property (p_od)
    else $error("open drain drives high");
  a_pp: assert property (p_pp)
    else $error("push-pull not driving");
  a_pol: assert property (p_pol)
    else $error("idle level wrong");
  a_pin_off: assert property (p_pin_off)
    else $error("disabled pin driven");
  a_pulse: assert property (p_pulse)
    else $error("pulse length wrong");
  a_hold: assert property (p_hold)
    else $error("held level dropped");
endmodule

// ==== tb/wake_event_indicator_tb.sv ====
`timescale 1ns/1ps
module wake_event_indicator_tb;
  import wei_pkg::*;
  localparam int PULSE = 20;
  logic sys_clk_i, rst_i, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic rsp_err, ready_seen, pme_level, irq, link_ev, energy_ev;
  logic link_pend, energy_pend, stable;
  logic [7:0] cmd_addr;
  logic [31:0] cmd_wdata, rsp_data, rsp;
  logic [1:0] pstate;
  int num_errors = 0;
  int tests_run = 0;
  wei_bus_if u_wei_bus_if ();
  wei_device #(.PULSE_CYCLES(PULSE)) u_wei_device (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .bus(u_wei_bus_if), .link_wake_event_i(link_ev),
    .energy_event_i(energy_ev), .link_src_pending_i(link_pend),
    .energy_src_pending_i(energy_pend), .stable_i(stable),
    .power_event_interrupt_o(irq), .power_state_select_o(pstate));
  wei_host u_wei_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus(u_wei_bus_if), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data),
    .ready_seen_o(ready_seen), .pme_level_o(pme_level));
  wei_props #(.PULSE_CYCLES(PULSE)) u_wei_props (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .addr(u_wei_bus_if.addr), .wr(u_wei_bus_if.wr),
    .rd(u_wei_bus_if.rd), .wdata(u_wei_bus_if.wdata),
    .rdata(u_wei_bus_if.rdata), .rvalid(u_wei_bus_if.rvalid),
    .pme_out(u_wei_bus_if.pme_out), .pme_oe(u_wei_bus_if.pme_oe));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (cmd_ready !== 1'b1 && n < 99) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge sys_clk_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 99) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 99) begin
      num_errors++;
    end
    rsp = rsp_data;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready_seen !== 1'b1 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(ready_seen, 1'b1);
  endtask
  // Event pulse, then time for the pin and its synchroniser to settle
  task automatic ev(input logic link);
    @(negedge sys_clk_i);
    link_ev = link;
    energy_ev = !link;
    @(negedge sys_clk_i);
    link_ev = 1'b0;
    energy_ev = 1'b0;
    repeat (6) @(negedge sys_clk_i);
  endtask
  task automatic t_ready;
    cmd(1'b0, 8'h80, '0);
    chk(rsp_err, 1'b1);
    cmd(1'b0, 8'h74, '0);
    chk(rsp_err, 1'b0);
    stable = 1'b1;
    wait_ready;
    cmd(1'b1, 8'h84, '0);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[0], 1'b1);
    chk(pstate, WEI_FULL_POWER_STATE);
  endtask
  task automatic t_held;
    cmd(1'b1, 8'h84, 32'h346);
    ev(1'b0);
    chk(irq, 1'b1);
    chk(pme_level, 1'b1);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_ENERGY);
    ev(1'b1);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_MULTI);
    energy_pend = 1'b1;
    cmd(1'b1, 8'h84, 32'h376);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_ENERGY);
    energy_pend = 1'b0;
    cmd(1'b1, 8'h84, 32'h356);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_NONE);
    repeat (6) @(negedge sys_clk_i);
    chk(pme_level, 1'b0);
  endtask
  // Active-low pulse
  task automatic t_pulse;
    cmd(1'b1, 8'h84, 32'h34a);
    ev(1'b1);
    chk(pme_level, 1'b0);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_FRAME);
    repeat (PULSE) @(negedge sys_clk_i);
    chk(pme_level, 1'b1);
    cmd(1'b1, 8'h84, 32'h36a);
  endtask
  task automatic t_od;
    cmd(1'b1, 8'h84, 32'h306);
    ev(1'b0);
    chk(u_wei_bus_if.pme_wire, 1'b0);
    cmd(1'b1, 8'h84, 32'h304);
    repeat (4) @(negedge sys_clk_i);
    chk(u_wei_bus_if.pme_wire, 1'b1);
    chk(irq, 1'b1);
    cmd(1'b1, 8'h84, 32'h344);
    repeat (6) @(negedge sys_clk_i);
    chk(u_wei_bus_if.pme_wire, 1'b0);
  endtask
  // Sleep, refused clear and reserved mode, then a wake event
  task automatic t_sleep;
    cmd(1'b1, 8'h84, 32'h2304);
    cmd(1'b1, 8'h84, 32'h3334);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_ENERGY);
    chk(rsp[13:12], WEI_ENERGY_WAKE_STATE);
    chk(rsp[0], 1'b0);
    ev(1'b0);
    chk(pstate, WEI_FULL_POWER_STATE);
    wait_ready;
    cmd(1'b1, 8'h84, 32'h334);
    cmd(1'b0, 8'h84, '0);
    chk(rsp[5:4], WEI_CAUSE_NONE);
    chk(irq, 1'b0);
  endtask
  task tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {rst_i, stable, link_pend, energy_pend} = 4'h8;
    {cmd_valid, cmd_write, link_ev, energy_ev} = 4'h0;
    cmd_addr = '0;
    cmd_wdata = '0;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_ready;
    t_held;
    t_pulse;
    t_od;
    t_sleep;
    tally_and_finish;
  end
endmodule
